// ---- shared/ssop_pkg.sv ----
package ssop_pkg;

  // register map
  localparam logic [15:0] CFG_ADDR = 16'h2070;
  localparam logic [15:0] BEG_ADDR = 16'h2071;
  localparam logic [15:0] END_ADDR = 16'h2072;
  localparam logic [15:0] STAT_ADDR = 16'h2073;

  // reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // serial clock timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_HZ = 5_000_000;
  localparam int FAST_HZ = 10_000_000;
  localparam logic [7:0] SLOW_HALF = 8'(CLK_HZ / (2 * SLOW_HZ));
  localparam logic [7:0] FAST_HALF = 8'(CLK_HZ / (2 * FAST_HZ));

  // data path
  localparam int WORD_BITS = 32;
  localparam int FIFO_DEPTH = 32;

  // frame pulse formats
  typedef enum logic [1:0] {
    FMT_BLOCK = 2'h0,
    FMT_8 = 2'h1,
    FMT_16 = 2'h2,
    FMT_32 = 2'h3
  } ssop_fmt_t;

  // configuration register layout, msb first
  typedef struct packed {
    logic port_enable;
    logic fast_clock_select;
    logic clock_gating_enable;
    ssop_fmt_t frame_format;
    logic frame_polarity;
    logic ready_output_enable;
    logic ready_polarity;
  } ssop_cfg_t;

  // status register layout, msb first
  typedef struct packed {
    logic [2:0] zero;
    logic enable_conflict;
    logic fetch_active;
    logic fifo_full;
    logic fifo_empty;
    logic block_busy;
  } ssop_stat_t;

  // one buffered word with its block-start marker
  typedef struct packed {
    logic first;
    logic [WORD_BITS-1:0] data;
  } ssop_word_t;

endpackage

// ---- verilog/ssop_fifo.sv ----
`timescale 1ns/100ps
module ssop_fifo #(
  parameter int W = 33,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != FULLC);
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (flush_i) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = (wp_r == LAST) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_nxt = (rp_r == LAST) ? '0 : rp_r + PW'(1);
      end
      if (push & ~pop) begin
        cnt_nxt = cnt_r + CW'(1);
      end else if (pop & ~push) begin
        cnt_nxt = cnt_r - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge clk_i) begin
    if (push & ~flush_i) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule // ssop_fifo

// ---- verilog/ssop_sclk_gen.sv ----
`timescale 1ns/100ps
module ssop_sclk_gen #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic [CW-1:0] half_i,
  input wire logic hold_i,
  // serial clock and bit boundary
  output logic sclk_o,
  output logic tick_o
);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic sclk_r, sclk_nxt;

  assign sclk_o = sclk_r;

  // tick marks a falling edge, or every cycle while held low
  always_comb begin
    cnt_nxt = cnt_r + CW'(1);
    sclk_nxt = sclk_r;
    tick_o = 1'b0;
    if (hold_i) begin
      cnt_nxt = '0;
      sclk_nxt = 1'b0;
      tick_o = 1'b1;
    end else if (cnt_r >= half_i - CW'(1)) begin
      cnt_nxt = '0;
      sclk_nxt = ~sclk_r;
      tick_o = sclk_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      sclk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sclk_r <= sclk_nxt;
    end
  end
endmodule // ssop_sclk_gen

// ---- verilog/ssop_top.sv ----
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - enable turns pins three-five into serial outputs
// - pin six is ready only with both enables
// - serial pins ignore display segment settings
// - speed bit picks 5 or 10 MHz
// - gating holds clock low while idle
// - format picks block, 8, 16, 32 bit frames
// - frame polarity bit inverts frame pulse
// - ready polarity bit inverts ready output
// - send words start through end address
module ssop_top (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  // register port
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // compute engine side
  input wire logic CE_PASS_START_I,
  input wire logic DISPLAY_ENABLE_I,
  output logic [7:0] MEM_ADDR_O,
  output logic MEM_RD_O,
  input wire logic [31:0] MEM_DATA_I,
  // segment pins, index 0 is pin three
  input wire logic [3:0] SEG_LCD_I,
  output logic [3:0] SEG_PIN_O
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {F_IDLE, F_READ, F_PUSH} ssop_fetch_t;
  typedef enum {S_IDLE, S_SHIFT} ssop_shift_t;

  localparam int WW = $bits(ssop_pkg::ssop_word_t);
  localparam int WB = ssop_pkg::WORD_BITS;
  localparam logic [4:0] LAST_BIT = 5'(WB - 1);

  ssop_pkg::ssop_cfg_t cfg_r, cfg_nxt;
  ssop_pkg::ssop_stat_t stat;
  logic [7:0] beg_r, beg_nxt, end_r, end_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  ssop_fetch_t f_r, f_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic first_r, first_nxt;
  logic push;
  ssop_pkg::ssop_word_t push_word, pop_word;
  logic [WW-1:0] pop_bits;
  logic in_ready, out_valid, pop;

  ssop_shift_t s_r, s_nxt;
  logic [WB-1:0] sh_r, sh_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic wfirst_r, wfirst_nxt;
  logic dout_r, dout_nxt, frm_r, frm_nxt;
  logic sclk, tick, hold, busy, load;
  logic [7:0] half;
  logic [3:0] pin_r, pin_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  assign REG_RDATA_O = rdata_r;
  assign stat.zero = 3'h0;
  assign stat.enable_conflict = cfg_r.port_enable & DISPLAY_ENABLE_I;
  assign stat.fetch_active = (f_r != F_IDLE);
  assign stat.fifo_full = ~in_ready;
  assign stat.fifo_empty = ~out_valid;
  assign stat.block_busy = busy;

  always_comb begin
    cfg_nxt = cfg_r;
    beg_nxt = beg_r;
    end_nxt = end_r;
    rdata_nxt = 8'h00;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ssop_pkg::CFG_ADDR: cfg_nxt = ssop_pkg::ssop_cfg_t'(REG_WDATA_I);
        ssop_pkg::BEG_ADDR: beg_nxt = REG_WDATA_I;
        ssop_pkg::END_ADDR: end_nxt = REG_WDATA_I;
        default: ;
      endcase
    end
    // unmapped reads answer zero
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ssop_pkg::CFG_ADDR: rdata_nxt = cfg_r;
        ssop_pkg::BEG_ADDR: rdata_nxt = beg_r;
        ssop_pkg::END_ADDR: rdata_nxt = end_r;
        ssop_pkg::STAT_ADDR: rdata_nxt = stat;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_r <= ssop_pkg::ssop_cfg_t'(ssop_pkg::CFG_RST);
      beg_r <= ssop_pkg::ADDR_RST;
      end_r <= ssop_pkg::ADDR_RST;
      rdata_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      beg_r <= beg_nxt;
      end_r <= end_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word fetch from data memory into the buffer
  assign MEM_ADDR_O = addr_r;
  assign push_word.first = first_r;
  assign push_word.data = MEM_DATA_I;

  always_comb begin
    f_nxt = f_r;
    addr_nxt = addr_r;
    first_nxt = first_r;
    MEM_RD_O = 1'b0;
    push = 1'b0;
    case (f_r)
      // a pass start while busy is ignored; the block must fit a pass
      F_IDLE: begin
        if (cfg_r.port_enable & CE_PASS_START_I & ~busy) begin
          addr_nxt = beg_r;
          first_nxt = 1'b1;
          f_nxt = F_READ;
        end
      end
      // read only with room, so the push next cycle is never refused
      F_READ: begin
        if (!cfg_r.port_enable) begin
          f_nxt = F_IDLE;
        end else if (in_ready) begin
          MEM_RD_O = 1'b1;
          f_nxt = F_PUSH;
        end
      end
      F_PUSH: begin
        push = 1'b1;
        first_nxt = 1'b0;
        if (addr_r == end_r) begin
          f_nxt = F_IDLE;
        end else begin
          addr_nxt = addr_r + 8'h01;
          f_nxt = F_READ;
        end
      end
      default: f_nxt = F_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      f_r <= F_IDLE;
      addr_r <= 8'h00;
      first_r <= 1'b0;
    end else begin
      f_r <= f_nxt;
      addr_r <= addr_nxt;
      first_r <= first_nxt;
    end
  end

  ssop_fifo #(
    .W(WW),
    .DEPTH(ssop_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .flush_i(~cfg_r.port_enable),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i(push_word),
    .out_valid_o(out_valid),
    .out_ready_i(pop),
    .out_data_o(pop_bits)
  );
  assign pop_word = ssop_pkg::ssop_word_t'(pop_bits);

  ////////////////////////////////////////////////////////////////////////////
  // serial clock
  // speed select
  assign half = cfg_r.fast_clock_select ? ssop_pkg::FAST_HALF : ssop_pkg::SLOW_HALF;
  assign hold = cfg_r.clock_gating_enable & (s_r != S_SHIFT);

  ssop_sclk_gen #(
    .CW(8)
  ) u_sclk (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .half_i(half),
    .hold_i(hold),
    .sclk_o(sclk),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shifter, msb first
  // frame position
  function automatic logic frame_hit(input logic [1:0] fmt, input logic [4:0] idx,
                                     input logic first);
    case (ssop_pkg::ssop_fmt_t'(fmt))
      ssop_pkg::FMT_BLOCK: frame_hit = first & (idx == 5'h00);
      ssop_pkg::FMT_8: frame_hit = (idx[2:0] == 3'h0);
      ssop_pkg::FMT_16: frame_hit = (idx[3:0] == 4'h0);
      ssop_pkg::FMT_32: frame_hit = (idx == 5'h00);
      default: frame_hit = 1'b0;
    endcase
  endfunction

  assign busy = (f_r != F_IDLE) | out_valid | (s_r == S_SHIFT);
  assign load = tick & ((s_r == S_IDLE) | (idx_r == LAST_BIT));
  assign pop = load & out_valid & cfg_r.port_enable;

  always_comb begin
    s_nxt = s_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    wfirst_nxt = wfirst_r;
    dout_nxt = dout_r;
    frm_nxt = frm_r;
    if (!cfg_r.port_enable) begin
      s_nxt = S_IDLE;
      dout_nxt = 1'b0;
      frm_nxt = 1'b0;
    end else if (pop) begin
      s_nxt = S_SHIFT;
      sh_nxt = {pop_word.data[WB-2:0], 1'b0};
      dout_nxt = pop_word.data[WB-1];
      idx_nxt = 5'h00;
      wfirst_nxt = pop_word.first;
      frm_nxt = frame_hit(cfg_r.frame_format, 5'h00, pop_word.first);
    end else if (load) begin
      s_nxt = S_IDLE;
      dout_nxt = 1'b0;
      frm_nxt = 1'b0;
    end else if (tick) begin
      sh_nxt = {sh_r[WB-2:0], 1'b0};
      dout_nxt = sh_r[WB-1];
      idx_nxt = idx_r + 5'h01;
      frm_nxt = frame_hit(cfg_r.frame_format, idx_r + 5'h01, wfirst_r);
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_r <= S_IDLE;
      sh_r <= '0;
      idx_r <= 5'h00;
      wfirst_r <= 1'b0;
      dout_r <= 1'b0;
      frm_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      wfirst_r <= wfirst_nxt;
      dout_r <= dout_nxt;
      frm_r <= frm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin multiplexer, registered so every pin has the same delay
  assign SEG_PIN_O = pin_r;

  always_comb begin
    pin_nxt = SEG_LCD_I;
    // port takes pins regardless of segment settings
    if (cfg_r.port_enable) begin
      pin_nxt[0] = sclk;
      pin_nxt[1] = dout_r;
      pin_nxt[2] = frm_r ^ cfg_r.frame_polarity;
    end
    if (cfg_r.port_enable & cfg_r.ready_output_enable) begin
      pin_nxt[3] = busy ^ cfg_r.ready_polarity;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pin_r <= 4'h0;
    end else begin
      pin_r <= pin_nxt;
    end
  end
endmodule // ssop_top

// ---- tb/ssop_top_props.sv ----
`timescale 1ns/100ps
module ssop_top_props (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  // register port
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  // memory and pins
  input wire logic [7:0] MEM_ADDR_O,
  input wire logic MEM_RD_O,
  input wire logic [3:0] SEG_LCD_I,
  input wire logic [3:0] SEG_PIN_O
);
  ssop_pkg::ssop_cfg_t cfg_r, cfg_nxt;
  logic [7:0] age_r, age_nxt, hi_r, hi_nxt;
  logic [1:0] up_r, up_nxt;
  logic en, rdy;
  assign en = cfg_r.port_enable;
  assign rdy = en & cfg_r.ready_output_enable;
  // shadow of config; age keeps checks off a freshly changed setting
  always_comb begin
    cfg_nxt = cfg_r;
    age_nxt = (age_r == 8'hff) ? age_r : age_r + 8'h01;
    if (REG_WR_I && REG_ADDR_I == ssop_pkg::CFG_ADDR) begin
      cfg_nxt = ssop_pkg::ssop_cfg_t'(REG_WDATA_I);
      age_nxt = 8'h00;
    end
    hi_nxt = SEG_PIN_O[0] ? hi_r + 8'h01 : 8'h00;
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
  end
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_r <= ssop_pkg::ssop_cfg_t'(ssop_pkg::CFG_RST);
      age_r <= 8'h00;
      hi_r <= 8'h00;
      up_r <= 2'h0;
    end else begin
      cfg_r <= cfg_nxt;
      age_r <= age_nxt;
      hi_r <= hi_nxt;
      up_r <= up_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_fetch;
    MEM_RD_O ##1 (!MEM_RD_O && $stable(MEM_ADDR_O));
  endsequence
  AST_PINS_DISPLAY: assert property (
    up_r == 2'h3 && !en && !$past(en) |-> SEG_PIN_O[2:0] == $past(SEG_LCD_I[2:0]))
    else $error("pins three to five not on display drive");
  AST_PIN_SIX: assert property (
    up_r == 2'h3 && !rdy && !$past(rdy) |-> SEG_PIN_O[3] == $past(SEG_LCD_I[3]))
    else $error("pin six not on display drive");
  AST_GATE_IDLE: assert property (
    rdy && cfg_r.clock_gating_enable && age_r > 8'h03
    && SEG_PIN_O[3] == cfg_r.ready_polarity && $past(SEG_PIN_O[3]) == cfg_r.ready_polarity
    |-> !SEG_PIN_O[0])
    else $error("gated serial clock not low while idle");
  // a config write landing inside the window may legally stop the clock
  AST_FREE_RUN: assert property (
    en && !cfg_r.clock_gating_enable && age_r > 8'h28
    |-> ##[1:11] ($changed(SEG_PIN_O[0]) || age_r == 8'h00))
    else $error("free serial clock stopped");
  AST_HALF_SLOW: assert property (
    en && !cfg_r.fast_clock_select && age_r > 8'h28 && $fell(SEG_PIN_O[0])
    |-> hi_r == ssop_pkg::SLOW_HALF)
    else $error("slow serial clock high phase wrong");
  AST_HALF_FAST: assert property (
    en && cfg_r.fast_clock_select && age_r > 8'h28 && $fell(SEG_PIN_O[0])
    |-> hi_r == ssop_pkg::FAST_HALF)
    else $error("fast serial clock high phase wrong");
  AST_DATA_ON_FALL: assert property (
    en && age_r > 8'h03 && $changed(SEG_PIN_O[2:1]) |-> !SEG_PIN_O[0])
    else $error("data or frame moved while serial clock high");
  AST_CFG_READ: assert property (
    REG_RD_I && REG_ADDR_I == ssop_pkg::CFG_ADDR |=> REG_RDATA_O == cfg_r)
    else $error("config readback wrong");
  AST_MEM_HOLD: assert property (
    MEM_RD_O |-> s_fetch)
    else $error("memory read not held or too close");
endmodule // ssop_top_props

// ---- tb/ssop_rx_model.sv ----
`timescale 1ns/100ps
module ssop_rx_model (
  // clock and pins
  input wire logic clk_i,
  input wire logic [3:0] pins_i,
  input wire logic fpol_i
);
  logic sclk_q = 1'b0;
  logic on = 1'b0;
  logic bits[$];
  logic frm[$];
  // capture starts at the first frame pulse, so free clocks before it are ignored
  always @(posedge clk_i) begin
    sclk_q <= pins_i[0];
    if (pins_i[0] && !sclk_q) begin
      if (on || (pins_i[2] ^ fpol_i)) begin
        on = 1'b1;
        bits.push_back(pins_i[1]);
        frm.push_back(pins_i[2] ^ fpol_i);
      end
    end
  end
endmodule // ssop_rx_model

// ---- tb/test_ssop_top.sv ----
`timescale 1ns/100ps
bind ssop_top ssop_top_props chk (.MCLK_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
  .REG_RD_I, .REG_RDATA_O, .MEM_ADDR_O, .MEM_RD_O, .SEG_LCD_I, .SEG_PIN_O);
module test_ssop_top;
  logic MCLK_I, RST_B_I, REG_WR_I, REG_RD_I, CE_PASS_START_I, DISPLAY_ENABLE_I, MEM_RD_O;
  logic [15:0] REG_ADDR_I;
  logic [7:0] REG_WDATA_I, REG_RDATA_O, MEM_ADDR_O, cf;
  logic [31:0] MEM_DATA_I, w;
  logic [3:0] SEG_LCD_I, SEG_PIN_O;
  int err_total = 0, comparisons = 0, cyc = 0, k;
  ssop_top uut (.MCLK_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
    .REG_RDATA_O, .CE_PASS_START_I, .DISPLAY_ENABLE_I, .MEM_ADDR_O, .MEM_RD_O,
    .MEM_DATA_I, .SEG_LCD_I, .SEG_PIN_O);
  ssop_rx_model rx (.clk_i(MCLK_I), .pins_i(SEG_PIN_O), .fpol_i(cf[2]));
  initial begin
    MCLK_I = 1'b0;
    forever #5 MCLK_I = ~MCLK_I;
  end
  function automatic logic [31:0] word(input logic [7:0] a);
    return {a, ~a, a ^ 8'h5a, a + 8'h11};
  endfunction
  // memory answers next cycle; otherwise the bus toggles so stale data never matches
  always @(posedge MCLK_I) MEM_DATA_I <= MEM_RD_O ? word(MEM_ADDR_O) : ~MEM_DATA_I;
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cv(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    cv({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge MCLK_I);
    REG_WR_I <= 1'b0;
    @(posedge MCLK_I);
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge MCLK_I);
    REG_RD_I <= 1'b0;
    #1 cv(REG_RDATA_O & m, e);
    @(posedge MCLK_I);
  endtask
  task automatic start_pass();
    CE_PASS_START_I <= 1'b1;
    @(posedge MCLK_I);
    CE_PASS_START_I <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    RST_B_I = 1'b0;
    {REG_WR_I, REG_RD_I, CE_PASS_START_I, DISPLAY_ENABLE_I} = 4'h0;
    REG_ADDR_I = 16'h0000;
    REG_WDATA_I = 8'h00;
    MEM_DATA_I = 32'h0;
    SEG_LCD_I = 4'ha;
    cf = 8'h00;
    repeat (10) @(posedge MCLK_I);
    RST_B_I <= 1'b1;
    @(posedge MCLK_I);
    rchk(16'h2070, 8'h00, 8'hff);
    wr(16'h2071, 8'h10);
    wr(16'h2072, 8'h11); // end above start
    wr(16'h2074, 8'hff);
    rchk(16'h2071, 8'h10, 8'hff);
    rchk(16'h2072, 8'h11, 8'hff);
    rchk(16'h2074, 8'h00, 8'hff);
    $display("test registers done");
    DISPLAY_ENABLE_I <= 1'b1;
    wr(16'h2070, 8'h02);
    repeat (3) @(posedge MCLK_I);
    cv(8'(SEG_PIN_O), 8'h0a);
    // display off while the port runs
    DISPLAY_ENABLE_I <= 1'b0;
    $display("test display pins done");
    for (int i = 0; i < 4; i++) begin
      cf = {1'b1, i[0], ~i[1], i[1:0], i[1], 1'b1, i[0] ^ i[1]};
      wr(16'h2070, cf);
      rx.on = 1'b0;
      rx.bits.delete();
      rx.frm.delete();
      start_pass(); // two words fit one pass
      repeat (300) @(posedge MCLK_I);
      cb(SEG_PIN_O[3], ~cf[0]);
      k = 0;
      while (rx.bits.size() < 64 && k < 3000) begin
        @(posedge MCLK_I);
        k++;
      end
      for (int b = 0; b < 64; b++) begin
        w = word(8'h10 + 8'(b / 32));
        cb(rx.bits[b], w[31 - b % 32]);
        cb(rx.frm[b], (i == 0) ? (b == 0) : (b % (4 << i) == 0));
      end
      repeat (100) @(posedge MCLK_I);
      cb(SEG_PIN_O[3], cf[0]);
      cb(SEG_PIN_O[2], cf[2]);
      $display("test stream %0d done", i);
    end
    // eighty words overrun the buffer, so fetching has to pause
    wr(16'h2072, 8'h5f);
    wr(16'h2070, 8'ha0);
    start_pass();
    repeat (200) @(posedge MCLK_I);
    rchk(16'h2073, 8'h0d, 8'hff);
    k = 0;
    repeat (100) begin
      @(posedge MCLK_I);
      k += int'(MEM_RD_O);
    end
    cv(8'(k), 8'h00);
    // one word shifting plus a full buffer leaves the fetch parked here
    cv(MEM_ADDR_O, 8'h10 + 8'(ssop_pkg::FIFO_DEPTH) + 8'h01);
    wr(16'h2070, 8'h00);
    rchk(16'h2073, 8'h02, 8'hff);
    repeat (3) @(posedge MCLK_I);
    cv(8'(SEG_PIN_O), 8'h0a);
    $display("test buffer and abort done");
    give_verdict();
  end
endmodule // test_ssop_top
